// ### fdf_defines.vh
// Shared constants for the FIR control/status block
`ifndef FDF_DEFINES_VH
`define FDF_DEFINES_VH
// Address map, byte addresses on the CSR bus
`define FDF_AW 13
`define FDF_OFF_CTRL 13'h0000
`define FDF_OFF_DECIM 13'h0004
`define FDF_OFF_LOAD 13'h000c
`define FDF_OFF_LDSTAT 13'h0010
`define FDF_OFF_INTEN 13'h0014
`define FDF_OFF_INTSTAT 13'h0018
`define FDF_OFF_INTFLAG 13'h001c
`define FDF_COEF_SEL_BIT 12
// Coefficient store
`define FDF_COEF_W 18
`define FDF_IDX_W 10
`define FDF_TAP_MULT 10'h01c
`define FDF_COEF_DEPTH 10'h380
// Decimation limits and reset values
`define FDF_DECIM_MIN 6'h02
`define FDF_DECIM_MAX 6'h20
`define FDF_RST_DECIM 6'h02
`define FDF_RST_CTRL 1'h0
`define FDF_RST_INTEN 1'h0
`define FDF_RST_FLAG 1'h0
// Field positions
`define FDF_BIT_SAT 0
`define FDF_BIT_BYPASS 0
`define FDF_BIT_LOAD 0
`define FDF_BIT_LDBUSY 0
`define FDF_BIT_LDDONE 1
// Bus responses
`define FDF_RESP_OKAY 2'h0
`define FDF_RESP_SLVERR 2'h2
`endif

// ### fdf_coef_loader.v
// Coefficient transfer engine from the store into the filter
`timescale 1ns/1ps
`include "fdf_defines.vh"

module fdf_coef_loader (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Control
  input wire start,
  input wire [`FDF_IDX_W-1:0] half_cnt,
  // Store read port
  output wire [`FDF_IDX_W-1:0] rd_idx,
  input wire [`FDF_COEF_W-1:0] rd_data,
  // Toward the filter; busy and done feed load status
  output wire [`FDF_COEF_W-1:0] coef_data,
  output wire [`FDF_IDX_W-1:0] coef_addr,
  output wire coef_wr,
  output wire busy,
  output wire done
);

localparam ST_IDLE = 2'b00;
localparam ST_RUN = 2'b01;

reg [1:0] state_r;
reg [`FDF_IDX_W-1:0] idx_r;
reg [`FDF_COEF_W-1:0] data_r;
reg [`FDF_IDX_W-1:0] addr_r;
reg wr_r;
reg busy_r;
reg done_r;

assign rd_idx = idx_r;
assign coef_data = data_r;
assign coef_addr = addr_r;
assign coef_wr = wr_r;
assign busy = busy_r;
assign done = done_r;

////////////////////////////////////////////////////////////////////////////////
// Walk first half only
always @(posedge mclk) begin
  if (!rst_n) begin
    state_r <= ST_IDLE;
    idx_r <= {`FDF_IDX_W{1'b0}};
    data_r <= {`FDF_COEF_W{1'b0}};
    addr_r <= {`FDF_IDX_W{1'b0}};
    wr_r <= 1'b0;
    busy_r <= 1'b0;
    done_r <= 1'b0;
  end else begin
    wr_r <= 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_r <= ST_RUN;
          idx_r <= {`FDF_IDX_W{1'b0}};
          busy_r <= 1'b1;
          done_r <= 1'b0;
        end
      end
      ST_RUN: begin
        data_r <= rd_data;
        addr_r <= idx_r;
        wr_r <= 1'b1;
        if (idx_r == half_cnt - 10'h001) begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          idx_r <= idx_r + 10'h001;
        end
      end
      default: begin
        state_r <= ST_IDLE;
      end
    endcase
  end
end

endmodule // fdf_coef_loader

// ### fdf_csr.v
// AXI4-Lite register slave, coefficient store and saturation interrupt
`timescale 1ns/1ps
`include "fdf_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Reset clears every interrupt flag bit.
// - Rising status sets its flag; flag holds after status falls.
// - Writing one to a flag bit clears only that bit.
// - Flags latch regardless of the interrupt enable setting.
// - Flag register at 0x001C, saturation in bit 0, rest reserved.
// - Saturation reported only while the filter is not bypassed.
// - Addresses 0x1000 to 0x1DFF reach the coefficient store.
// - Each coefficient word is 18 bits wide.
// - Up to 28 times the decimation factor coefficients.
// - Only the first half of the coefficient set is used.
// - Stream-side signals belong to the stream clock domain.
// - Bus, registers and coefficient store run on the CSR clock.
// - Stream reset is active low, synchronous to its clock.
// - CSR reset is active low, synchronous to the CSR clock.
// - Enabled source rising edge gives a one-cycle interrupt pulse.
// - Interrupt output is the OR of enabled sources.
// - A held condition gives no new pulse without a new edge.
// - Status bits show the live condition.
// - Enable register at 0x0014 gates each interrupt source.
// - Status register at 0x0018, saturation bit 0, live.
// - Load status at 0x0010: bit 0 in progress, bit 1 complete.
module fdf_csr (
  // CSR clock and active-low reset
  input wire mclk,
  input wire rst_n,
  // Stream-domain inputs
  input wire stream_rst_n,
  input wire sat_raw,
  // AXI4-Lite write address
  input wire [`FDF_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [`FDF_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Filter configuration
  output wire bypass_en,
  output wire [5:0] decim_factor,
  // Coefficients toward the filter
  output wire [`FDF_COEF_W-1:0] coef_data,
  output wire [`FDF_IDX_W-1:0] coef_addr,
  output wire coef_wr,
  // Interrupt
  output wire irq
);

////////////////////////////////////////////////////////////////////////////////
// Functions

function [31:0] strb_merge;
  input [31:0] old_v;
  input [31:0] new_v;
  input [3:0] strb;
  integer i;
  begin
    for (i = 0; i < 4; i = i + 1) begin
      strb_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  end
endfunction

// Word address is in the coefficient window
function coef_hit;
  input [`FDF_AW-1:0] addr;
  begin
    coef_hit = addr[`FDF_COEF_SEL_BIT];
  end
endfunction

// Coefficient word exists behind this address
function coef_ok;
  input [`FDF_AW-1:0] addr;
  begin
    coef_ok = (addr[11:2] < `FDF_COEF_DEPTH);
  end
endfunction

function reg_known;
  input [`FDF_AW-1:0] w;
  begin
    reg_known = (w == `FDF_OFF_CTRL) || (w == `FDF_OFF_DECIM) ||
                (w == `FDF_OFF_LOAD) || (w == `FDF_OFF_LDSTAT) ||
                (w == `FDF_OFF_INTEN) || (w == `FDF_OFF_INTSTAT) ||
                (w == `FDF_OFF_INTFLAG);
  end
endfunction

function [5:0] clamp_decim;
  input [5:0] d;
  begin
    if (d < `FDF_DECIM_MIN) begin
      clamp_decim = `FDF_DECIM_MIN;
    end else if (d > `FDF_DECIM_MAX) begin
      clamp_decim = `FDF_DECIM_MAX;
    end else begin
      clamp_decim = d;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Declarations

reg awready_r;
reg wready_r;
reg bvalid_r;
reg [1:0] bresp_r;
reg arready_r;
reg rvalid_r;
reg [1:0] rresp_r;
reg [31:0] rdata_r;
reg ctrl_bypass_r;
reg [5:0] decim_r;
reg load_bit_r;
reg load_start_r;
reg inten_r;
reg flag_r;
reg flag_nxt;
reg irq_r;
reg [2:0] sat_sync_r;
reg [2:0] srst_sync_r;
reg sat_live_r;
reg srst_live_r;
reg stat_prev_r;
reg [31:0] rd_mux;
reg rd_err;
reg [`FDF_COEF_W-1:0] coef_mem [0:`FDF_COEF_DEPTH-1];

wire wr_fire;
wire rd_fire;
wire [`FDF_AW-1:0] wr_word;
wire [`FDF_AW-1:0] rd_word;
wire wr_reg;
wire wr_coef;
wire [31:0] wr_merged;
wire [31:0] mem_old;
wire [31:0] mem_merged;
wire flag_clr;
wire sat_stat;
wire sat_rise;
wire [`FDF_IDX_W-1:0] tap_total;
wire [`FDF_IDX_W-1:0] half_cnt;
wire [`FDF_IDX_W-1:0] ld_idx;
wire [`FDF_COEF_W-1:0] ld_rd_data;
wire ld_busy;
wire coef_load_complete;

assign s_axi_awready = awready_r;
assign s_axi_wready = wready_r;
assign s_axi_bvalid = bvalid_r;
assign s_axi_bresp = bresp_r;
assign s_axi_arready = arready_r;
assign s_axi_rvalid = rvalid_r;
assign s_axi_rresp = rresp_r;
assign s_axi_rdata = rdata_r;
assign bypass_en = ctrl_bypass_r;
assign decim_factor = decim_r;
assign irq = irq_r;

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite handshakes

assign wr_fire = s_axi_awvalid & s_axi_wvalid & awready_r & wready_r;
assign rd_fire = s_axi_arvalid & arready_r;
assign wr_word = {s_axi_awaddr[`FDF_AW-1:2], 2'b00};
assign rd_word = {s_axi_araddr[`FDF_AW-1:2], 2'b00};
assign wr_coef = wr_fire & coef_hit(wr_word);
assign wr_reg = wr_fire & ~coef_hit(wr_word);

always @(posedge mclk) begin
  if (!rst_n) begin
    awready_r <= 1'b0;
    wready_r <= 1'b0;
    bvalid_r <= 1'b0;
    bresp_r <= `FDF_RESP_OKAY;
  end else begin
    awready_r <= s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
    wready_r <= s_axi_awvalid & s_axi_wvalid & ~wready_r & ~bvalid_r;
    if (wr_fire) begin
      bvalid_r <= 1'b1;
      if (coef_hit(wr_word) ? coef_ok(wr_word) : reg_known(wr_word)) begin
        bresp_r <= `FDF_RESP_OKAY;
      end else begin
        bresp_r <= `FDF_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
end

always @(posedge mclk) begin
  if (!rst_n) begin
    arready_r <= 1'b0;
    rvalid_r <= 1'b0;
    rresp_r <= `FDF_RESP_OKAY;
    rdata_r <= 32'h0000_0000;
  end else begin
    arready_r <= s_axi_arvalid & ~arready_r & ~rvalid_r;
    if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_err ? `FDF_RESP_SLVERR : `FDF_RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Coefficient store

assign mem_old = {14'h0000, coef_mem[s_axi_awaddr[11:2]]};
assign mem_merged = strb_merge(mem_old, s_axi_wdata, s_axi_wstrb);
assign ld_rd_data = coef_mem[ld_idx];

always @(posedge mclk) begin
  if (wr_coef && coef_ok(wr_word)) begin
    coef_mem[s_axi_awaddr[11:2]] <= mem_merged[`FDF_COEF_W-1:0];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration registers

assign wr_merged = strb_merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
// Tap count is 28 times decimation
assign tap_total = {4'h0, decim_r} * `FDF_TAP_MULT;
assign half_cnt = tap_total >> 1;

always @(posedge mclk) begin
  if (!rst_n) begin
    ctrl_bypass_r <= `FDF_RST_CTRL;
    decim_r <= `FDF_RST_DECIM;
    load_bit_r <= 1'b0;
    load_start_r <= 1'b0;
    inten_r <= `FDF_RST_INTEN;
  end else begin
    load_start_r <= 1'b0;
    if (wr_reg && wr_word == `FDF_OFF_CTRL && s_axi_wstrb[0]) begin
      ctrl_bypass_r <= wr_merged[`FDF_BIT_BYPASS];
    end
    if (wr_reg && wr_word == `FDF_OFF_DECIM && s_axi_wstrb[0]) begin
      decim_r <= clamp_decim(wr_merged[5:0]);
    end
    if (wr_reg && wr_word == `FDF_OFF_LOAD && s_axi_wstrb[0]) begin
      load_bit_r <= wr_merged[`FDF_BIT_LOAD];
      load_start_r <= wr_merged[`FDF_BIT_LOAD] & ~load_bit_r;
    end
    if (wr_reg && wr_word == `FDF_OFF_INTEN && s_axi_wstrb[0]) begin
      inten_r <= wr_merged[`FDF_BIT_SAT];
    end
  end
end

fdf_coef_loader u_loader (
  .mclk (mclk),
  .rst_n (rst_n),
  .start (load_start_r),
  .half_cnt (half_cnt),
  .rd_idx (ld_idx),
  .rd_data (ld_rd_data),
  .coef_data (coef_data),
  .coef_addr (coef_addr),
  .coef_wr (coef_wr),
  .busy (ld_busy),
  .done (coef_load_complete)
);

////////////////////////////////////////////////////////////////////////////////
// Saturation source crossing

// Three stages, second and third agree
always @(posedge mclk) begin
  if (!rst_n) begin
    sat_sync_r <= 3'h0;
    srst_sync_r <= 3'h0;
    sat_live_r <= 1'b0;
    srst_live_r <= 1'b0;
  end else begin
    sat_sync_r <= {sat_sync_r[1:0], sat_raw};
    srst_sync_r <= {srst_sync_r[1:0], stream_rst_n};
    if (sat_sync_r[1] == sat_sync_r[2]) begin
      sat_live_r <= sat_sync_r[2];
    end
    if (srst_sync_r[1] == srst_sync_r[2]) begin
      srst_live_r <= srst_sync_r[2];
    end
  end
end

// Stream reset low masks the source
assign sat_stat = sat_live_r & srst_live_r & ~ctrl_bypass_r;
assign sat_rise = sat_stat & ~stat_prev_r;
assign flag_clr = wr_reg & (wr_word == `FDF_OFF_INTFLAG) & s_axi_wstrb[0] &
                  s_axi_wdata[`FDF_BIT_SAT];

////////////////////////////////////////////////////////////////////////////////
// Interrupt flag and pulse

always @* begin
  flag_nxt = flag_r;
  if (flag_clr) begin
    flag_nxt = 1'b0;
  end
  if (sat_rise) begin
    flag_nxt = 1'b1;
  end
end

always @(posedge mclk) begin
  if (!rst_n) begin
    flag_r <= `FDF_RST_FLAG;
    stat_prev_r <= 1'b0;
    irq_r <= 1'b0;
  end else begin
    flag_r <= flag_nxt;
    stat_prev_r <= sat_stat;
    irq_r <= sat_rise & inten_r;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read multiplexer

always @* begin
  rd_mux = 32'h0000_0000;
  rd_err = 1'b0;
  if (coef_hit(rd_word)) begin
    if (coef_ok(rd_word)) begin
      rd_mux[`FDF_COEF_W-1:0] = coef_mem[s_axi_araddr[11:2]];
    end else begin
      rd_err = 1'b1;
    end
  end else begin
    case (rd_word)
      `FDF_OFF_CTRL: rd_mux[`FDF_BIT_BYPASS] = ctrl_bypass_r;
      `FDF_OFF_DECIM: rd_mux[5:0] = decim_r;
      `FDF_OFF_LOAD: rd_mux[`FDF_BIT_LOAD] = load_bit_r;
      `FDF_OFF_LDSTAT: begin
        rd_mux[`FDF_BIT_LDBUSY] = ld_busy;
        rd_mux[`FDF_BIT_LDDONE] = coef_load_complete;
      end
      `FDF_OFF_INTEN: rd_mux[`FDF_BIT_SAT] = inten_r;
      `FDF_OFF_INTSTAT: rd_mux[`FDF_BIT_SAT] = sat_stat;
      // Flag in bit 0, rest zero
      `FDF_OFF_INTFLAG: rd_mux[`FDF_BIT_SAT] = flag_r;
      default: rd_err = 1'b1;
    endcase
  end
end

endmodule // fdf_csr

// ### fdf_csr_chk.sv
// Port-level assertions for the CSR block
`timescale 1ns/1ps
module fdf_csr_chk (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [12:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Filter side
  input wire bypass_en,
  input wire [9:0] coef_addr,
  input wire coef_wr,
  input wire irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_irq_one_cycle: assert property (irq |=> !irq)
    else $error("irq longer than one cycle");
  a_irq_no_bypass: assert property (irq |-> !$past(bypass_en))
    else $error("irq while bypassed");
  a_reset_quiet: assert property ($rose(rst_n) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs busy after reset");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid)
    else $error("no write response");
  a_coef_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[12] |=>
    s_axi_rvalid && s_axi_rdata[31:18] == 14'h0 &&
    s_axi_rresp == (&$past(s_axi_araddr[11:9]) ? 2'h2 : 2'h0))
    else $error("bad coefficient read");
  a_load_from_zero: assert property ($rose(coef_wr) |-> coef_addr == 10'h0)
    else $error("load not starting at word 0");
  c_irq: cover property (irq);
  c_load: cover property ($rose(coef_wr));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // fdf_csr_chk
bind fdf_csr fdf_csr_chk i_chk (
  .mclk(mclk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bypass_en(bypass_en),
  .coef_addr(coef_addr), .coef_wr(coef_wr), .irq(irq));

// ### fdf_stream_model.sv
// Stream-side model: saturation source and coefficient sink
`timescale 1ns/1ps
module fdf_stream_model (
  // Clock
  input wire mclk,
  // Toward the block
  output logic stream_rst_n,
  output logic sat_raw,
  // Coefficients from the block
  input wire [17:0] coef_data,
  input wire [9:0] coef_addr,
  input wire coef_wr
);
  logic [17:0] got [0:895];
  int wr_cnt = 0;
  initial begin
    stream_rst_n = 1'b0;
    sat_raw = 1'b0;
    #3000 stream_rst_n = 1'b1;
  end
  task set_sat(input logic v);
    sat_raw = v;
  endtask
  always @(posedge mclk) begin
    if (coef_wr === 1'b1) begin
      got[coef_addr] <= coef_data;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule // fdf_stream_model

// ### testbench.sv
// Self-checking bench for the CSR block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  logic mclk = 1'b0, rst_n = 1'b0;
  logic [12:0] s_axi_awaddr = 13'h0, s_axi_araddr = 13'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire bypass_en, coef_wr, irq, stream_rst_n, sat_raw;
  wire [5:0] decim_factor;
  wire [17:0] coef_data;
  wire [9:0] coef_addr;
  int err_total = 0, n_compared = 0, cyc = 0, irq_cnt = 0, k;
  logic [31:0] rd;
  logic [1:0] rs;
  always #50 mclk = ~mclk;
  fdf_csr i_fdf_csr (.mclk(mclk), .rst_n(rst_n), .stream_rst_n(stream_rst_n),
    .sat_raw(sat_raw), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bypass_en(bypass_en),
    .decim_factor(decim_factor), .coef_data(coef_data), .coef_addr(coef_addr),
    .coef_wr(coef_wr), .irq(irq));
  fdf_stream_model i_fdf_stream_model (.mclk(mclk), .stream_rst_n(stream_rst_n),
    .sat_raw(sat_raw), .coef_data(coef_data), .coef_addr(coef_addr), .coef_wr(coef_wr));
  ////////////////////////////////////////////////////////////////////////////
  task results;
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cyc == 20000) begin
      err_total++;
      results;
    end
  end
  // Bus tasks, entered and left at a falling edge
  task wr(input logic [12:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr = a;
    s_axi_wdata = d;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    while (!(s_axi_awready && s_axi_wready)) @(negedge mclk);
    @(negedge mclk);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    while (s_axi_bvalid !== 1'b1) @(negedge mclk);
    // One cycle of back-pressure before accepting
    @(negedge mclk);
    s_axi_bready = 1'b1;
    r = s_axi_bresp;
    @(negedge mclk);
    s_axi_bready = 1'b0;
  endtask
  task rdr(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    while (s_axi_arready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    s_axi_arvalid = 1'b0;
    while (s_axi_rvalid !== 1'b1) @(negedge mclk);
    // One cycle of back-pressure before accepting
    @(negedge mclk);
    s_axi_rready = 1'b1;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(negedge mclk);
    s_axi_rready = 1'b0;
  endtask
  task wchk(input logic [12:0] a, input logic [31:0] d, input logic [1:0] er);
    wr(a, d, rs);
    `CHK("bresp", er, rs)
  endtask
  task rchk(input logic [12:0] a, input logic [31:0] e, input logic [1:0] er);
    rdr(a, rd, rs);
    `CHK("rdata", e, rd)
    `CHK("rresp", er, rs)
  endtask
  task sat(input logic v);
    i_fdf_stream_model.set_sat(v);
    repeat (10) @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (30) @(negedge mclk);
    rchk(13'h001c, 32'h0, 2'h0);
    rchk(13'h0014, 32'h0, 2'h0);
    wchk(13'h0000, 32'h0, 2'h0);
    // symmetric even set of 56 words
    for (k = 0; k < 28; k++) begin
      wchk(13'h1000 + 13'(4 * k), 32'h1000 + k, 2'h0);
      wchk(13'h1000 + 13'(4 * (55 - k)), 32'h1000 + k, 2'h0);
    end
    wchk(13'h1190, 32'hffffffff, 2'h0);
    rchk(13'h1190, 32'h0003ffff, 2'h0);
    rchk(13'h10dc, 32'h1000, 2'h0);
    rchk(13'h1e00, 32'h0, 2'h2);
    wchk(13'h0020, 32'h1, 2'h2);
    wchk(13'h000c, 32'h0, 2'h0);
    wchk(13'h000c, 32'h1, 2'h0);
    repeat (40) @(negedge mclk);
    rchk(13'h0010, 32'h2, 2'h0);
    `CHK("coef count", 28, i_fdf_stream_model.wr_cnt)
    for (k = 0; k < 28; k++)
      `CHK("coef", 18'(32'h1000 + k), i_fdf_stream_model.got[k])
    wchk(13'h0004, 32'h3f, 2'h0);
    rchk(13'h0004, 32'h20, 2'h0);
    wchk(13'h0004, 32'h1, 2'h0);
    `CHK("decim", 6'h02, decim_factor)
    wchk(13'h0004, 32'h4, 2'h0);
    // 56 symmetric taps centred in 112, zero pads
    for (k = 0; k < 56; k++) begin
      wchk(13'h1000 + 13'(4 * k), (k < 28) ? 32'h0 : 32'h2000 + k, 2'h0);
      wchk(13'h1000 + 13'(4 * (111 - k)), (k < 28) ? 32'h0 : 32'h2000 + k, 2'h0);
    end
    wchk(13'h000c, 32'h0, 2'h0);
    wchk(13'h000c, 32'h1, 2'h0);
    repeat (70) @(negedge mclk);
    rchk(13'h0010, 32'h2, 2'h0);
    `CHK("coef count", 84, i_fdf_stream_model.wr_cnt)
    for (k = 0; k < 56; k++)
      `CHK("coef pad", (k < 28) ? 18'h0 : 18'(32'h2000 + k), i_fdf_stream_model.got[k])
    sat(1'b1);
    `CHK("irq off", 0, irq_cnt)
    rchk(13'h0018, 32'h1, 2'h0);
    rchk(13'h001c, 32'h1, 2'h0);
    sat(1'b0);
    rchk(13'h0018, 32'h0, 2'h0);
    rchk(13'h001c, 32'h1, 2'h0);
    wchk(13'h001c, 32'hfffffffe, 2'h0);
    rchk(13'h001c, 32'h1, 2'h0);
    wchk(13'h001c, 32'h1, 2'h0);
    rchk(13'h001c, 32'h0, 2'h0);
    wchk(13'h0014, 32'h1, 2'h0);
    sat(1'b1);
    sat(1'b1);
    `CHK("irq pulses", 1, irq_cnt)
    sat(1'b0);
    sat(1'b1);
    `CHK("irq pulses", 2, irq_cnt)
    sat(1'b0);
    wchk(13'h0000, 32'h1, 2'h0);
    `CHK("bypass", 1'b1, bypass_en)
    sat(1'b1);
    `CHK("irq bypass", 2, irq_cnt)
    rchk(13'h0018, 32'h0, 2'h0);
    sat(1'b0);
    rchk(13'h001c, 32'h1, 2'h0);
    // Mid-run reset must clear a latched flag
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    rchk(13'h001c, 32'h0, 2'h0);
    rchk(13'h0000, 32'h0, 2'h0);
    `CHK("bypass reset", 1'b0, bypass_en)
    `CHK("decim reset", 6'h02, decim_factor)
    results;
  end
endmodule // testbench
